// file: src/lrc_pkg.sv
// Purpose: Shared constants and carrier types for the row refresh chain.
// Assumes: Core clock of 100 MHz; shift clock runs in its own domain.
// Notes: Panel, chain and timing figures live here; synchroniser depths are set in the modules.
package lrc_pkg;

  localparam int LRC_STAGES = 40;
  localparam int LRC_COLS = 36;
  localparam int LRC_ROWS = 24;
  localparam int LRC_ROW_W = 5;

  localparam logic [4:0] LRC_ROW_NONE = 5'h00;
  localparam logic [4:0] LRC_ROW_FIRST = 5'h01;
  localparam logic [4:0] LRC_ROW_LAST = 5'h18;

  // Rated ceiling of the host's shift clock, kept for reference
  localparam int LRC_SHIFT_MAX_KHZ = 6000;

  // Latch-to-latch gap beyond which the panel flickers and a row overdrives
  localparam int LRC_CLOCK_MHZ = 100;
  localparam int LRC_FLICKER_US = 1200;
  localparam int LRC_FLICKER_CYCLES = LRC_FLICKER_US * LRC_CLOCK_MHZ;

  typedef struct packed {
    logic [LRC_ROW_W-1:0] index;
    logic [LRC_COLS-1:0] pixels;
  } lrc_row_t;

endpackage

// file: src/lrc_shift_link.sv
// Purpose: Serial shift register clocked by the host's shift clock.
// Assumes: Shift clock idles high and may stand still between rows.
// Notes: Reset reaches this domain through a two-stage synchroniser.
`timescale 1ns/1ps
`default_nettype none
module lrc_shift_link
  import lrc_pkg::*;
(
  input wire logic i_shift_clock,
  input wire logic i_rstn,
  input wire logic i_serial_in,
  output logic o_serial_out,
  output logic [lrc_pkg::LRC_STAGES-1:0] o_shift_word
);
  import lrc_pkg::*;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [5:0] warm;
    logic [LRC_STAGES-1:0] stages;
  } lrc_link_state_t;

  lrc_link_state_t state_ff;
  lrc_link_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.rst_sync = {state_ff.rst_sync[0], i_rstn};
    if (!state_ff.rst_sync[1]) begin
      nxt_state.stages = '0;
      nxt_state.warm = 6'h00;
    end else begin
      // Edges since reset, saturating; only gates the checks below
      if (state_ff.warm != 6'h3f) begin
        nxt_state.warm = state_ff.warm + 6'h01;
      end
      // Stage 1 takes the pin; every stage moves one place on
      nxt_state.stages = {state_ff.stages[LRC_STAGES-2:0], i_serial_in};
    end
  end

  // Rising edge of the shift clock advances the chain
  always_ff @(posedge i_shift_clock) begin
    state_ff <= nxt_state;
  end

  assign o_shift_word = state_ff.stages;
  assign o_serial_out = state_ff.stages[LRC_STAGES-1];

  shift_in_a: assert property (
    @(posedge i_shift_clock) disable iff (!state_ff.rst_sync[1])
    state_ff.warm > 6'h01 |-> state_ff.stages[0] == $past(i_serial_in))
    else $error("stage one did not take the serial input");

  chain_depth_a: assert property (
    @(posedge i_shift_clock) disable iff (!state_ff.rst_sync[1])
    state_ff.warm > 6'h29 |-> state_ff.stages[LRC_STAGES-1] ==
      $past(state_ff.stages[0], 39))
    else $error("shift chain is not forty stages deep");

  serial_out_a: assert property (
    @(posedge i_shift_clock) disable iff (!state_ff.rst_sync[1])
    state_ff.warm > 6'h2a |-> o_serial_out == $past(i_serial_in, 40))
    else $error("serial output is not the fortieth bit shifted in");

endmodule
`default_nettype wire

// file: src/lrc_row_refresh.sv
// Purpose: Row refresh receiver for one 36x24 panel module in a chain.
// Assumes: Host shifts a whole row, then pulses the row latch while the
//   shift clock stands still; marker and latch are asynchronous pins.
// Notes: Frame store models the row driver's energised pixels.
// Behaviour
// - Forty-stage shift register fed by serial input, clocked by shift clock.
// - Only stages 1 to 36 drive columns; stages 37 to 40 ignored.
// - Serial output shows stage 40 to feed the next module.
// - First four bits ignored; fifth is rightmost, fortieth is leftmost pixel.
// - A one turns a pixel on, a zero turns it off.
// - Each latch moves the shift contents into the current row.
`timescale 1ns/1ps
`default_nettype none
module lrc_row_refresh
  import lrc_pkg::*;
#(
  parameter int FLICKER_CYCLES = lrc_pkg::LRC_FLICKER_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  input wire logic i_serial_shift_clock,
  input wire logic i_serial_in,
  input wire logic i_first_row_marker,
  input wire logic i_row_latch_pulse,
  input wire logic [lrc_pkg::LRC_ROW_W-1:0] i_read_row,
  output logic o_serial_out,
  output lrc_pkg::lrc_row_t o_row,
  output logic o_row_strobe,
  output logic o_frame_start,
  output logic [lrc_pkg::LRC_COLS-1:0] o_read_pixels,
  output logic o_refresh_stale
);
  import lrc_pkg::*;

  localparam int CNT_W = $clog2(FLICKER_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(FLICKER_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  typedef struct packed {
    logic [1:0] latch_sync;
    logic [1:0] mark_sync;
    logic latch_prev;
    logic [LRC_ROW_W-1:0] row;
    logic strobe;
    logic frame_start;
    logic [LRC_COLS-1:0] pixels;
    logic [LRC_ROWS-1:0][LRC_COLS-1:0] frame;
    logic [LRC_COLS-1:0] read_pixels;
    logic [CNT_W-1:0] idle_cnt;
    logic stale;
  } lrc_core_state_t;

  lrc_core_state_t state_ff;
  lrc_core_state_t nxt_state;

  logic [LRC_STAGES-1:0] shift_word;
  logic latch_rise;
  logic mark_now;
  logic [LRC_ROW_W-1:0] nxt_row;
  logic [LRC_ROWS-1:0] row_sel;

  lrc_shift_link u_link (
    .i_shift_clock(i_serial_shift_clock),
    .i_rstn(i_rstn),
    .i_serial_in(i_serial_in),
    .o_serial_out(o_serial_out),
    .o_shift_word(shift_word)
  );

  // Only the second synchroniser stage feeds the edge detector
  assign latch_rise = state_ff.latch_sync[1] & ~state_ff.latch_prev;
  assign mark_now = state_ff.mark_sync[1];

  // Marker at the latch restarts the frame; otherwise step one row.
  // Running past the last row wraps so a missing marker cannot stall us.
  always_comb begin
    if (mark_now) begin
      nxt_row = LRC_ROW_FIRST;
    end else if (state_ff.row == LRC_ROW_LAST) begin
      nxt_row = LRC_ROW_FIRST;
    end else begin
      nxt_row = state_ff.row + LRC_ROW_FIRST;
    end
  end

  // One write select per frame-store row; row n lives in entry n-1
  for (genvar g = 0; g < LRC_ROWS; g++) begin : g_row_sel
    assign row_sel[g] = (nxt_row == LRC_ROW_W'(g + 1));
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.latch_sync = {state_ff.latch_sync[0], i_row_latch_pulse};
    nxt_state.mark_sync = {state_ff.mark_sync[0], i_first_row_marker};
    nxt_state.latch_prev = state_ff.latch_sync[1];
    nxt_state.strobe = 1'b0;
    nxt_state.frame_start = 1'b0;
    if (state_ff.idle_cnt != CNT_LIMIT) begin
      nxt_state.idle_cnt = state_ff.idle_cnt + CNT_ONE;
    end
    nxt_state.stale = (state_ff.idle_cnt == CNT_LIMIT);
    if (latch_rise) begin
      // Shift clock is still by now, so the word is quasi-static and safe
      // to take across domains; stages above the columns are dropped.
      nxt_state.pixels = shift_word[LRC_COLS-1:0];
      nxt_state.row = nxt_row;
      nxt_state.strobe = 1'b1;
      nxt_state.frame_start = mark_now;
      // Column 0 is leftmost: stage 1 holds the last bit shifted in
      for (int r = 0; r < LRC_ROWS; r++) begin
        if (row_sel[r]) begin
          nxt_state.frame[r] = shift_word[LRC_COLS-1:0];
        end
      end
      nxt_state.idle_cnt = '0;
      nxt_state.stale = 1'b0;
    end
    if (i_read_row >= LRC_ROW_FIRST && i_read_row <= LRC_ROW_LAST) begin
      nxt_state.read_pixels = state_ff.frame[i_read_row - LRC_ROW_FIRST];
    end else begin
      nxt_state.read_pixels = '0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_ff <= '0;
    end else if (i_clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign o_row.index = state_ff.row;
  assign o_row.pixels = state_ff.pixels;
  assign o_row_strobe = state_ff.strobe;
  assign o_frame_start = state_ff.frame_start;
  assign o_read_pixels = state_ff.read_pixels;
  assign o_refresh_stale = state_ff.stale;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);

  latch_capture_a: assert property (
    latch_rise && i_clk_en |=> o_row_strobe)
    else $error("row latch did not produce a row strobe");

  first_row_a: assert property (
    latch_rise && mark_now && i_clk_en |=>
      o_row.index == LRC_ROW_FIRST && o_frame_start)
    else $error("marker at latch did not select the first row");

  unused_stages_a: assert property (
    latch_rise && i_clk_en |=>
      o_row.pixels == $past(shift_word[LRC_COLS-1:0]))
    else $error("latched row does not match stages one to 36");

  pixel_order_a: assert property (
    latch_rise && i_clk_en |=>
      o_row.pixels[0] == $past(shift_word[0]) &&
      o_row.pixels[LRC_COLS-1] == $past(shift_word[LRC_COLS-1]))
    else $error("leftmost or rightmost pixel taken from wrong stage");

  pixel_store_a: assert property (
    o_row_strobe && i_clk_en |=>
      state_ff.frame[$past(o_row.index) - LRC_ROW_FIRST] ==
      $past(o_row.pixels))
    else $error("energised row differs from latched pixels");

  // Latches need a low phase in between, so a strobe never lasts two enabled cycles
  strobe_pulse_a: assert property (
    o_row_strobe && i_clk_en |=> !o_row_strobe)
    else $error("row strobe stood for more than one cycle");

  frame_start_pair_a: assert property (
    o_frame_start |-> o_row_strobe && o_row.index == LRC_ROW_FIRST)
    else $error("frame start without a first-row strobe");

  row_step_a: assert property (
    latch_rise && !mark_now && i_clk_en &&
      state_ff.row != LRC_ROW_LAST |=>
      o_row.index == $past(state_ff.row) + LRC_ROW_FIRST)
    else $error("row index did not step by one");

  // A frame cut short or overrun must not stall the row pointer
  row_wrap_a: assert property (
    latch_rise && !mark_now && i_clk_en &&
      state_ff.row == LRC_ROW_LAST |=> o_row.index == LRC_ROW_FIRST)
    else $error("row index did not wrap after the last row");

  row_range_a: assert property (
    o_row_strobe |->
      o_row.index >= LRC_ROW_FIRST && o_row.index <= LRC_ROW_LAST)
    else $error("strobed row index out of range");

  stale_set_a: assert property (
    state_ff.idle_cnt == CNT_LIMIT && !latch_rise && i_clk_en |=>
      o_refresh_stale)
    else $error("stale flag missing after a long latch gap");

  stale_clear_a: assert property (
    latch_rise && i_clk_en |=> !o_refresh_stale)
    else $error("stale flag not cleared by a latch");

  // Enable low must hold every core flop, including the synchronisers
  freeze_a: assert property (
    !i_clk_en |=> $stable(state_ff))
    else $error("core state moved while the clock enable was low");

  read_port_a: assert property (
    i_read_row >= LRC_ROW_FIRST && i_read_row <= LRC_ROW_LAST &&
      i_clk_en |=>
      o_read_pixels == $past(state_ff.frame[i_read_row - LRC_ROW_FIRST]))
    else $error("read port does not show the stored row");

  read_empty_a: assert property (
    (i_read_row < LRC_ROW_FIRST || i_read_row > LRC_ROW_LAST) &&
      i_clk_en |=> o_read_pixels == '0)
    else $error("read of a missing row is not zero");

  cover_frame_c: cover property (latch_rise && mark_now);
  cover_last_row_c: cover property (
    o_row_strobe && o_row.index == LRC_ROW_LAST);
  cover_partial_c: cover property (
    o_frame_start && $past(o_row.index) != LRC_ROW_LAST);
  cover_stale_c: cover property (o_refresh_stale);

endmodule
`default_nettype wire

// file: dv/lrc_host_model.sv
// Purpose: Host model driving shift, marker and latch pins of one module.
// Assumes: Shift clock period 48 ns, standing still between rows.
// Notes: Released data line shows the inverse of its last bit.
`timescale 1ns/1ps
`default_nettype none
module lrc_host_model (
  output logic o_sck,
  output logic o_sdi,
  output logic o_marker,
  output logic o_latch
);
  initial begin
    o_sck = 1'b1;
    o_sdi = 1'b0;
    o_marker = 1'b0;
    o_latch = 1'b0;
  end
  // Bit 39 goes first, so bit c of the word lands in column c
  task automatic shift_word(input logic [39:0] w);
    for (int k = 39; k >= 0; k--) begin
      o_sck = 1'b0;
      o_sdi = w[k];
      #24 o_sck = 1'b1;
      #24;
    end
    o_sdi = ~w[0];
  endtask
  // Fixed timing keeps latch spacing equal and well under the flicker limit
  task automatic row(input logic [39:0] w, input logic first);
    o_marker = first;
    #30 shift_word(w);
    #30 o_latch = 1'b1;
    #60 o_latch = 1'b0;
    #30 o_marker = 1'b0;
    #60;
  endtask
endmodule
`default_nettype wire

// file: dv/lrc_row_refresh_bench.sv
// Purpose: Self-checking bench for the row refresh receiver.
// Assumes: Staleness limit shortened to 50 core cycles.
// Notes: Expected pixels are bits 35..0 of the word shifted.
`timescale 1ns/1ps
`default_nettype none
module lrc_row_refresh_bench;
  import lrc_pkg::*;
  localparam int STALE = 50;
  logic i_clock, i_rstn, i_clk_en, sck, sdi, marker, latch;
  logic [LRC_ROW_W-1:0] i_read_row;
  logic o_serial_out, o_row_strobe, o_frame_start, o_refresh_stale;
  lrc_row_t o_row;
  logic [LRC_COLS-1:0] o_read_pixels;
  logic [35:0] exp_mem [1:24];
  int n_fail = 0;
  int tests_run = 0;
  lrc_host_model lrc_host_model_i (.o_sck(sck), .o_sdi(sdi),
    .o_marker(marker), .o_latch(latch));
  lrc_row_refresh #(.FLICKER_CYCLES(STALE)) lrc_row_refresh_i (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_clk_en(i_clk_en),
    .i_serial_shift_clock(sck), .i_serial_in(sdi),
    .i_first_row_marker(marker), .i_row_latch_pulse(latch),
    .i_read_row(i_read_row), .o_serial_out(o_serial_out),
    .o_row(o_row), .o_row_strobe(o_row_strobe),
    .o_frame_start(o_frame_start), .o_read_pixels(o_read_pixels),
    .o_refresh_stale(o_refresh_stale));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  task automatic finish_test;
    $display("Checks %0d, failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input logic [41:0] got, input logic [41:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send_row(input logic [39:0] w, input logic first,
                          input logic [4:0] idx);
    int n;
    exp_mem[idx] = w[35:0];
    fork
      lrc_host_model_i.row(w, first);
      begin
        for (n = 0; n < 400 && o_row_strobe !== 1'b1; n++) begin
          @(negedge i_clock);
        end
        if (n == 400) begin
          n_fail++;
          finish_test();
        end else begin
          cmp({o_frame_start, o_row}, {first, idx, w[35:0]});
        end
      end
    join
    cmp({41'h0, o_serial_out}, {41'h0, w[39]});
    cmp({41'h0, o_refresh_stale}, 42'h0);
  endtask
  // Top bit alternates so the chain output sees both levels
  task automatic frame_scan;
    logic [39:0] w;
    for (int r = 1; r <= 24; r++) begin
      w = 40'hA5_3C96_E1F0 ^ {r[0], 34'h0, r[4:0]};
      send_row(w, r == 1, r[4:0]);
    end
    send_row(40'hF0_0000_0000, 1'b0, 5'h01);
  endtask
  task automatic read_back(input logic [4:0] r, input logic [35:0] exp);
    @(posedge i_clock);
    i_read_row <= r;
    repeat (2) @(negedge i_clock);
    cmp({6'h0, o_read_pixels}, {6'h0, exp});
  endtask
  // Enable low first: the idle count must not run while frozen
  task automatic stale_check;
    @(posedge i_clock);
    i_clk_en <= 1'b0;
    repeat (STALE * 2) @(negedge i_clock);
    cmp({41'h0, o_refresh_stale}, 42'h0);
    @(posedge i_clock);
    i_clk_en <= 1'b1;
    repeat (STALE + 10) @(negedge i_clock);
    cmp({41'h0, o_refresh_stale}, 42'h1);
    send_row(40'h0F_FFFF_FFFF, 1'b1, 5'h01);
  endtask
  initial begin
    i_rstn = 1'b0;
    i_clk_en = 1'b1;
    i_read_row = 5'h00;
    // Shift edges during reset let the link domain see it and clear
    @(negedge i_clock);
    fork
      lrc_host_model_i.shift_word(40'h00_0000_0000);
      begin
        repeat (6) @(posedge i_clock);
        @(negedge i_clock);
        cmp({o_row_strobe, o_row}, 42'h0);
        @(posedge i_clock);
        i_rstn <= 1'b1;
      end
    join
    frame_scan();
    read_back(5'h07, exp_mem[7]);
    read_back(5'h00, 36'h0_0000_0000);
    stale_check();
    finish_test();
  end
endmodule
`default_nettype wire
